// ==== verilog/pdwc_params.svh ====
`ifndef PDWC_PARAMS_SVH
`define PDWC_PARAMS_SVH

// Subsystem decode windows on the low eight address bits: match when (addr & mask) == base.
`define PDWC_NDMA_BASE    8'h00
`define PDWC_NDMA_MASK    8'hF0
`define PDWC_PIRQ_BASE    8'h20
`define PDWC_PIRQ_MASK    8'hFE
`define PDWC_CONF_BASE    8'h22
`define PDWC_CONF_MASK    8'hFE
`define PDWC_CTU_BASE     8'h40
`define PDWC_CTU_MASK     8'hFC
`define PDWC_RTC_BASE     8'h71
`define PDWC_RTC_MASK     8'hFF
`define PDWC_PAGE_BASE    8'h80
`define PDWC_PAGE_MASK    8'hF0
`define PDWC_SIRQ_BASE    8'hA0
`define PDWC_SIRQ_MASK    8'hFE
`define PDWC_WDMA_BASE    8'hC0
`define PDWC_WDMA_MASK    8'hE0

// Index and data ports of the configuration window.
`define PDWC_INDEX_PORT   8'h22
`define PDWC_DATA_PORT    8'h23
`define PDWC_CFG_INDEX    8'h01
`define PDWC_INDEX_RESET  8'h00
`define PDWC_UNMAPPED_RD  8'hFF

// Register cycle_timing_config at index 01H of data port 23H.
`define PDWC_CFG_RESET    8'hC0
`define PDWC_CPU_WAIT_HI  7
`define PDWC_CPU_WAIT_LO  6
`define PDWC_WIDE_WAIT_HI 5
`define PDWC_WIDE_WAIT_LO 4
`define PDWC_NARR_WAIT_HI 3
`define PDWC_NARR_WAIT_LO 2
`define PDWC_EARLY_MEMR   1
`define PDWC_CLK_BYPASS   0

// A wait field value n gives n + 1 wait states of one system clock each.
`define PDWC_WAIT_BASE    3'h1

`endif

// ==== verilog/pdwc_pkg.sv ====
package pdwc_pkg;

   typedef enum logic [4:0] {
      PDWC_DMA_IDLE   = 5'b00001,
      PDWC_DMA_LEAD   = 5'b00010,
      PDWC_DMA_WAIT   = 5'b00100,
      PDWC_DMA_EXTEND = 5'b01000,
      PDWC_DMA_DONE   = 5'b10000
   } pdwc_dma_state_t;

   // Bit positions of the subsystem enable vector.
   typedef enum int {
      PDWC_SUB_NDMA = 0,
      PDWC_SUB_PIRQ = 1,
      PDWC_SUB_CONF = 2,
      PDWC_SUB_CTU  = 3,
      PDWC_SUB_RTC  = 4,
      PDWC_SUB_PAGE = 5,
      PDWC_SUB_SIRQ = 6,
      PDWC_SUB_WDMA = 7
   } pdwc_sub_t;

   typedef logic [7:0] pdwc_sel_t;
   typedef logic [7:0] pdwc_byte_t;
   typedef logic [9:0] pdwc_addr_t;
   typedef logic [1:0] pdwc_wait_field_t;

endpackage

// ==== verilog/pdwc_dma_clk.sv ====
`timescale 1ns/1ns
module pdwc_dma_clk (
   input  wire logic clk,        // System clock.
   input  wire logic rst_n,      // Asynchronous reset, active low.
   input  wire logic bypass,     // High runs DMA at the full system rate.
   output logic      dma_clk_en  // Enable pulse marking each DMA clock.
);

   logic sync1_q;
   logic sync2_q;
   logic mode_q;
   logic phase_q;
   logic en_q;
   logic en_d;

   // The new rate only takes effect at the end of a divided period, so a
   // DMA clock is never shortened by a change in the middle of it.
   assign en_d = mode_q | phase_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         mode_q  <= 1'b0;
         phase_q <= 1'b0;
         en_q    <= 1'b0;
      end else begin
         sync1_q <= bypass;
         sync2_q <= sync1_q;
         phase_q <= ~phase_q;
         if (phase_q) begin
            mode_q <= sync2_q;
         end
         en_q <= en_d;
      end
   end

   assign dma_clk_en = en_q;

endmodule // pdwc_dma_clk

// ==== verilog/pdwc_top.sv ====
`timescale 1ns/1ns
`include "pdwc_params.svh"

module pdwc_top #(
   parameter int DATA_W = 8    // Width of the peripheral data bus.
) (
   input  wire logic                CLK,             // System clock.
   input  wire logic                RESETN,          // Asynchronous reset, active low.
   input  wire pdwc_pkg::pdwc_addr_t PERIPH_ADDR,    // Peripheral address bus.
   input  wire logic                DMA_GRANT,       // High while no DMA owns the bus.
   input  wire logic                IO_READ_STROBE_N,  // I/O read strobe, active low.
   input  wire logic                IO_WRITE_STROBE_N, // I/O write strobe, active low.
   input  wire logic [DATA_W-1:0]   PERIPH_DATA_IN,  // Data bus as seen at the pins.
   output logic      [DATA_W-1:0]   PERIPH_DATA_OUT, // Data driven onto the bus.
   output logic                     PERIPH_DATA_OE,  // High while data is driven.
   input  wire logic [DATA_W-1:0]   SUB_RDATA,       // Read data from the enabled subsystem.
   output pdwc_pkg::pdwc_sel_t      SUB_ENABLE,      // One-hot subsystem enables.
   input  wire logic                CHANNEL_READY_IN,  // Channel ready level at the pin.
   output logic                     CHANNEL_READY_OUT, // Channel ready drive value.
   output logic                     CHANNEL_READY_OE,  // High while pulling ready low.
   input  wire logic                DMA_START,       // One-cycle pulse starting a DMA cycle.
   input  wire logic                DMA_WIDE,        // High for a 16-bit DMA cycle.
   output logic                     DMA_IO_READ_N,   // DMA I/O read command, active low.
   output logic                     DMA_MEMORY_READ_N, // DMA memory read command, active low.
   output logic                     DMA_DONE,        // One-cycle pulse at end of DMA cycle.
   output logic                     DMA_CLK_EN,      // DMA clock enable pulse.
   output pdwc_pkg::pdwc_byte_t     CFG_VALUE        // Current configuration register.
);

   import pdwc_pkg::*;

   // Wait states for a two-bit field; shared by CPU and both DMA widths.
   function automatic logic [2:0] wait_cycles(input pdwc_wait_field_t field);
      wait_cycles = {1'b0, field} + `PDWC_WAIT_BASE;
   endfunction

   function automatic logic window_hit(input pdwc_byte_t addr,
                                       input pdwc_byte_t base,
                                       input pdwc_byte_t mask);
      window_hit = ((addr & mask) == base);
   endfunction

   localparam pdwc_byte_t SUB_BASE [8] = '{`PDWC_NDMA_BASE, `PDWC_PIRQ_BASE,
                                          `PDWC_CONF_BASE, `PDWC_CTU_BASE,
                                          `PDWC_RTC_BASE,  `PDWC_PAGE_BASE,
                                          `PDWC_SIRQ_BASE, `PDWC_WDMA_BASE};
   localparam pdwc_byte_t SUB_MASK [8] = '{`PDWC_NDMA_MASK, `PDWC_PIRQ_MASK,
                                          `PDWC_CONF_MASK, `PDWC_CTU_MASK,
                                          `PDWC_RTC_MASK,  `PDWC_PAGE_MASK,
                                          `PDWC_SIRQ_MASK, `PDWC_WDMA_MASK};

   // ---------------- Top-level decode ----------------
   pdwc_sel_t  sel_d;
   pdwc_sel_t  sel_q;
   logic       decode_allow;
   logic       any_hit;
   logic       ior_act;
   logic       iow_act;
   logic       ior_prev_q;
   logic       iow_prev_q;
   logic       access_start;
   logic       write_start;
   pdwc_byte_t addr_lo;

   assign addr_lo      = PERIPH_ADDR[7:0];
   assign decode_allow = DMA_GRANT & ~PERIPH_ADDR[9] & ~PERIPH_ADDR[8];

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_decode
         // Unlisted addresses leave every enable low.
         assign sel_d[gi] = decode_allow & window_hit(addr_lo, SUB_BASE[gi],
                                                      SUB_MASK[gi]);
      end
   endgenerate

   assign any_hit      = |sel_d;
   assign ior_act      = ~IO_READ_STROBE_N;
   assign iow_act      = ~IO_WRITE_STROBE_N;
   // An access is counted once, on the cycle its strobe first appears.
   assign access_start = any_hit & ((ior_act & ~ior_prev_q) | (iow_act & ~iow_prev_q));
   assign write_start  = iow_act & ~iow_prev_q;

   // ---------------- Configuration window ----------------
   pdwc_byte_t index_q;
   pdwc_byte_t index_d;
   pdwc_byte_t cfg_q;
   pdwc_byte_t cfg_d;
   pdwc_byte_t cfg_rdata;
   logic       hit_index;
   logic       hit_data;
   logic       cfg_selected;

   assign hit_index    = sel_d[PDWC_SUB_CONF] & (addr_lo == `PDWC_INDEX_PORT);
   assign hit_data     = sel_d[PDWC_SUB_CONF] & (addr_lo == `PDWC_DATA_PORT);
   assign cfg_selected = (index_q == `PDWC_CFG_INDEX);

   assign index_d = (write_start & hit_index) ? PERIPH_DATA_IN[7:0] : index_q;
   assign cfg_d   = (write_start & hit_data & cfg_selected) ?
                    PERIPH_DATA_IN[7:0] : cfg_q;

   // Other indices are not implemented here and read back as all ones.
   assign cfg_rdata = hit_index    ? index_q :
                      cfg_selected ? cfg_q   : `PDWC_UNMAPPED_RD;

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         index_q <= `PDWC_INDEX_RESET;
         cfg_q   <= `PDWC_CFG_RESET;
      end else begin
         index_q <= index_d;
         cfg_q   <= cfg_d;
      end
   end

   // ---------------- Data buffer control ----------------
   logic [DATA_W-1:0] data_d;
   logic [DATA_W-1:0] data_q;
   logic              data_oe_d;
   logic              data_oe_q;

   assign data_oe_d = any_hit & ior_act;
   assign data_d    = sel_d[PDWC_SUB_CONF] ?
                      {{(DATA_W-8){1'b0}}, cfg_rdata} : SUB_RDATA;

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         data_q     <= '0;
         data_oe_q  <= 1'b0;
         sel_q      <= '0;
         ior_prev_q <= 1'b0;
         iow_prev_q <= 1'b0;
      end else begin
         data_q     <= data_d;
         data_oe_q  <= data_oe_d;
         sel_q      <= sel_d;
         ior_prev_q <= ior_act;
         iow_prev_q <= iow_act;
      end
   end

   // ---------------- CPU wait states ----------------
   // Counted in system clocks so the divider setting never stretches them.
   logic [2:0] cpu_cnt_q;
   logic [2:0] cpu_cnt_d;
   logic       rdy_oe_q;
   logic       rdy_out_q;

   assign cpu_cnt_d = access_start ?
                      wait_cycles(cfg_q[`PDWC_CPU_WAIT_HI:`PDWC_CPU_WAIT_LO]) :
                      (cpu_cnt_q != 3'h0) ? cpu_cnt_q - 3'h1 : 3'h0;

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         cpu_cnt_q <= 3'h0;
         rdy_oe_q  <= 1'b0;
         rdy_out_q <= 1'b0;
      end else begin
         cpu_cnt_q <= cpu_cnt_d;
         rdy_oe_q  <= (cpu_cnt_d != 3'h0);
         rdy_out_q <= 1'b0;
      end
   end

   // ---------------- DMA command timing ----------------
   pdwc_dma_state_t dma_state_q;
   pdwc_dma_state_t dma_state_d;
   logic [2:0]      dma_cnt_q;
   logic [2:0]      dma_cnt_d;
   logic            early_memr;
   logic [2:0]      dma_waits;
   logic            dma_ior_n_q;
   logic            dma_ior_n_d;
   logic            dma_memr_n_q;
   logic            dma_memr_n_d;
   logic            dma_done_q;
   logic            dma_done_d;

   assign early_memr = cfg_q[`PDWC_EARLY_MEMR];
   assign dma_waits  = DMA_WIDE ?
                       wait_cycles(cfg_q[`PDWC_WIDE_WAIT_HI:`PDWC_WIDE_WAIT_LO]) :
                       wait_cycles(cfg_q[`PDWC_NARR_WAIT_HI:`PDWC_NARR_WAIT_LO]);

   always_comb begin
      dma_state_d  = dma_state_q;
      dma_cnt_d    = dma_cnt_q;
      dma_ior_n_d  = dma_ior_n_q;
      dma_memr_n_d = dma_memr_n_q;
      dma_done_d   = 1'b0;
      case (dma_state_q)
         PDWC_DMA_IDLE: begin
            if (DMA_START) begin
               dma_cnt_d   = dma_waits;
               dma_ior_n_d = 1'b0;
               if (early_memr) begin
                  dma_memr_n_d = 1'b0;
                  dma_state_d  = PDWC_DMA_WAIT;
               end else begin
                  dma_state_d  = PDWC_DMA_LEAD;
               end
            end
         end
         PDWC_DMA_LEAD: begin
            dma_memr_n_d = 1'b0;
            dma_state_d  = PDWC_DMA_WAIT;
         end
         PDWC_DMA_WAIT: begin
            if (dma_cnt_q > 3'h1) begin
               dma_cnt_d = dma_cnt_q - 3'h1;
            end else if (CHANNEL_READY_IN) begin
               dma_cnt_d   = 3'h0;
               dma_state_d = PDWC_DMA_DONE;
            end else begin
               dma_cnt_d   = 3'h0;
               dma_state_d = PDWC_DMA_EXTEND;
            end
         end
         PDWC_DMA_EXTEND: begin
            // A slow peripheral holds ready low; the cycle waits without limit.
            if (CHANNEL_READY_IN) begin
               dma_state_d = PDWC_DMA_DONE;
            end
         end
         PDWC_DMA_DONE: begin
            dma_ior_n_d  = 1'b1;
            dma_memr_n_d = 1'b1;
            dma_done_d   = 1'b1;
            dma_state_d  = PDWC_DMA_IDLE;
         end
         default: begin
            dma_ior_n_d  = 1'b1;
            dma_memr_n_d = 1'b1;
            dma_cnt_d    = 3'h0;
            dma_state_d  = PDWC_DMA_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         dma_state_q  <= PDWC_DMA_IDLE;
         dma_cnt_q    <= 3'h0;
         dma_ior_n_q  <= 1'b1;
         dma_memr_n_q <= 1'b1;
         dma_done_q   <= 1'b0;
      end else begin
         dma_state_q  <= dma_state_d;
         dma_cnt_q    <= dma_cnt_d;
         dma_ior_n_q  <= dma_ior_n_d;
         dma_memr_n_q <= dma_memr_n_d;
         dma_done_q   <= dma_done_d;
      end
   end

   // ---------------- DMA clock rate ----------------
   pdwc_dma_clk u_dma_clk (
      .clk        (CLK),
      .rst_n      (RESETN),
      .bypass     (cfg_q[`PDWC_CLK_BYPASS]),
      .dma_clk_en (DMA_CLK_EN)
   );

   // ---------------- Outputs ----------------
   assign PERIPH_DATA_OUT   = data_q;
   assign PERIPH_DATA_OE    = data_oe_q;
   assign SUB_ENABLE        = sel_q;
   assign CHANNEL_READY_OUT = rdy_out_q;
   assign CHANNEL_READY_OE  = rdy_oe_q;
   assign DMA_IO_READ_N     = dma_ior_n_q;
   assign DMA_MEMORY_READ_N = dma_memr_n_q;
   assign DMA_DONE          = dma_done_q;
   assign CFG_VALUE         = cfg_q;

endmodule // pdwc_top

// ==== test/pdwc_assertions.sv ====
`timescale 1ns/1ns
module pdwc_checker (
   input wire logic                 CLK,               // System clock.
   input wire logic                 RESETN,            // Reset, active low.
   input wire pdwc_pkg::pdwc_addr_t PERIPH_ADDR,       // Address bus.
   input wire logic                 DMA_GRANT,         // Decode allowed.
   input wire logic                 IO_READ_STROBE_N,  // Read strobe.
   input wire logic                 IO_WRITE_STROBE_N, // Write strobe.
   input wire logic                 PERIPH_DATA_OE,    // Data drive.
   input wire pdwc_pkg::pdwc_sel_t  SUB_ENABLE,        // Enables.
   input wire logic                 CHANNEL_READY_IN,  // Ready wire.
   input wire logic                 CHANNEL_READY_OE,  // Ready pull.
   input wire logic                 DMA_IO_READ_N,     // DMA read.
   input wire logic                 DMA_MEMORY_READ_N, // DMA memory read.
   input wire logic                 DMA_DONE,          // DMA end.
   input wire logic                 DMA_CLK_EN,        // DMA clock.
   input wire pdwc_pkg::pdwc_byte_t CFG_VALUE          // Configuration.
);
   import pdwc_pkg::*;
   logic [7:0] a;
   logic       ok;
   pdwc_sel_t  dec;
   assign a = PERIPH_ADDR[7:0];
   assign ok = DMA_GRANT && PERIPH_ADDR[9:8] == 2'h0;
   assign dec = ok ? {a >= 8'hC0 && a <= 8'hDF, a[7:1] == 7'h50, a[7:4] == 4'h8, a == 8'h71,
                      a[7:2] == 6'h10, a[7:1] == 7'h11, a[7:1] == 7'h10, a[7:4] == 4'h0}
                   : 8'h00;
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESETN);
   sequence s_take;
      $fell(IO_READ_STROBE_N && IO_WRITE_STROBE_N) && dec != 8'h00;
   endsequence
   sequence s_free;
      !CHANNEL_READY_OE;
   endsequence
   a_ready_one_wait: assert property (s_take ##0 CFG_VALUE[7:6] == 2'h0 |=>
      CHANNEL_READY_OE ##1 s_free) else $error("ready pull not one cycle");
   a_ready_two_wait: assert property (s_take ##0 CFG_VALUE[7:6] == 2'h1 |=>
      CHANNEL_READY_OE [*2] ##1 s_free) else $error("ready pull not two cycles");
   a_ready_three_wait: assert property (s_take ##0 CFG_VALUE[7:6] == 2'h2 |=>
      CHANNEL_READY_OE [*3] ##1 s_free) else $error("ready pull not three cycles");
   a_ready_four_wait: assert property (s_take ##0 CFG_VALUE[7:6] == 2'h3 |=>
      CHANNEL_READY_OE [*4] ##1 s_free) else $error("ready pull not four cycles");
   a_enable_match: assert property (SUB_ENABLE != 8'h00 |-> SUB_ENABLE == $past(dec))
      else $error("enable does not match decode");
   a_enable_quiet: assert property (dec == 8'h00 |=> SUB_ENABLE == 8'h00)
      else $error("enable without valid decode");
   a_oe_cause: assert property (PERIPH_DATA_OE ==
      $past(!IO_READ_STROBE_N && dec != 8'h00)) else $error("data drive does not follow read");
   a_dma_early_read: assert property ($fell(DMA_IO_READ_N) |-> if (CFG_VALUE[1])
      !DMA_MEMORY_READ_N else (DMA_MEMORY_READ_N ##1 !DMA_MEMORY_READ_N))
      else $error("memory read timing wrong");
   a_dma_end_ready: assert property (DMA_DONE |-> DMA_IO_READ_N && DMA_MEMORY_READ_N &&
      $past(!DMA_IO_READ_N) && $past(CHANNEL_READY_IN, 2)) else $error("DMA end wrong");
   a_clk_half_rate: assert property (DMA_CLK_EN && !CFG_VALUE[0] &&
      !$past(CFG_VALUE[0], 4) |=> !DMA_CLK_EN) else $error("divided clock too fast");
   a_clk_full_rate: assert property (CFG_VALUE[0] && $past(CFG_VALUE[0], 8) |->
      DMA_CLK_EN) else $error("bypass clock missing");
   a_cfg_reset_value: assert property ($rose(RESETN) |-> CFG_VALUE == 8'hC0)
      else $error("configuration reset value wrong");
endmodule // pdwc_checker
bind pdwc_top pdwc_checker u_chk (.CLK, .RESETN, .PERIPH_ADDR, .DMA_GRANT, .IO_READ_STROBE_N,
   .IO_WRITE_STROBE_N, .PERIPH_DATA_OE, .SUB_ENABLE, .CHANNEL_READY_IN, .CHANNEL_READY_OE,
   .DMA_IO_READ_N, .DMA_MEMORY_READ_N, .DMA_DONE, .DMA_CLK_EN, .CFG_VALUE);

// ==== test/pdwc_host.sv ====
`timescale 1ns/1ns
module pdwc_host (
   input  wire logic                 CLK,   // System clock.
   input  wire logic                 RDY,   // Channel ready wire.
   input  wire pdwc_pkg::pdwc_byte_t BUS,   // Data wire.
   output pdwc_pkg::pdwc_addr_t      ADDR,  // Address.
   output logic                      RD_N,  // Read strobe.
   output logic                      WR_N,  // Write strobe.
   output pdwc_pkg::pdwc_byte_t      WDATA  // Write data.
);
   import pdwc_pkg::*;
   initial begin
      ADDR = 10'h3FF;
      RD_N = 1'b1;
      WR_N = 1'b1;
      WDATA = 8'h00;
   end
   // The strobe stands two edges before ready is looked at, since the pull is registered.
   task automatic io(input logic wr, input pdwc_addr_t a, input pdwc_byte_t d,
                     output pdwc_byte_t q, output int w);
      w = 0;
      @(posedge CLK);
      ADDR <= a;
      WDATA <= d;
      RD_N <= wr;
      WR_N <= !wr;
      @(posedge CLK);
      do begin
         @(posedge CLK);
         w++;
      end while (RDY !== 1'b1 && w < 16);
      w--;
      q = BUS;
      RD_N <= 1'b1;
      WR_N <= 1'b1;
      // Released lines show the inverse so stale values are never mistaken for live ones.
      ADDR <= ~a;
      WDATA <= ~d;
   endtask
endmodule // pdwc_host

// ==== test/tb_peripheral_decode_wait_control.sv ====
`timescale 1ns/1ns
module tb_peripheral_decode_wait_control;
   import pdwc_pkg::*;
   logic       clk, rst_n, grant, dstart, dwide, pull, rdy, rdy_out;
   logic       oe, rdy_oe, dio_n, dmr_n, done, clk_en, rd_n, wr_n;
   pdwc_addr_t addr;
   pdwc_byte_t wdata, bus, dout, sub_rd, cfg, q;
   pdwc_sel_t  sel;
   int         errors, total_checks, w;
   // Ready and data lines have pull-ups.
   assign rdy = (rdy_oe ? rdy_out : 1'b1) && !pull;
   assign bus = oe ? dout : (!wr_n ? wdata : 8'hFF);
   pdwc_top dut (.CLK(clk), .RESETN(rst_n), .PERIPH_ADDR(addr), .DMA_GRANT(grant),
      .IO_READ_STROBE_N(rd_n), .IO_WRITE_STROBE_N(wr_n), .PERIPH_DATA_IN(bus),
      .PERIPH_DATA_OUT(dout), .PERIPH_DATA_OE(oe), .SUB_RDATA(sub_rd), .SUB_ENABLE(sel),
      .CHANNEL_READY_IN(rdy), .CHANNEL_READY_OUT(rdy_out), .CHANNEL_READY_OE(rdy_oe),
      .DMA_START(dstart), .DMA_WIDE(dwide), .DMA_IO_READ_N(dio_n),
      .DMA_MEMORY_READ_N(dmr_n), .DMA_DONE(done), .DMA_CLK_EN(clk_en), .CFG_VALUE(cfg));
   pdwc_host host (.CLK(clk), .RDY(rdy), .BUS(bus), .ADDR(addr), .RD_N(rd_n), .WR_N(wr_n),
      .WDATA(wdata));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic check(input string n, input pdwc_byte_t s, input pdwc_byte_t e);
      total_checks++;
      if (s !== e) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic acc(input logic wr, input pdwc_addr_t a, input pdwc_byte_t d);
      host.io(wr, a, d, q, w);
   endtask
   task automatic set_cfg(input pdwc_byte_t v);
      acc(1'b1, 10'h022, 8'h01);
      acc(1'b1, 10'h023, v);
      check("cfg", cfg, v);
   endtask
   task automatic t_reset();
      check("cfg_rst", cfg, 8'hC0);
      acc(1'b0, 10'h022, 8'h00);
      check("index", q, 8'h00);
      check("rdy_out", {7'h00, rdy_out}, 8'h00);
   endtask
   task automatic t_decode();
      pdwc_addr_t ta[20];
      int         ti[20];
      ta = '{10'h000, 10'h00F, 10'h020, 10'h021, 10'h040, 10'h043, 10'h071, 10'h080, 10'h08F,
             10'h0A0, 10'h0A1, 10'h0C0, 10'h0DF, 10'h010, 10'h024, 10'h070, 10'h0E0, 10'h120,
             10'h240, 10'h040};
      ti = '{0, 0, 1, 1, 3, 3, 4, 5, 5, 6, 6, 7, 7, 8, 8, 8, 8, 8, 8, 8};
      for (int i = 0; i < 20; i++) begin
         @(posedge clk);
         grant <= (i != 19);
         acc(1'b0, ta[i], 8'h00);
         check("enable", sel, ti[i] < 8 ? 8'h01 << ti[i] : 8'h00);
         check("data", q, ti[i] < 8 ? 8'h5A : 8'hFF);
         check("waits", 8'(w), ti[i] < 8 ? 8'h04 : 8'h00);
         repeat (2) @(posedge clk);
         check("oe_off", {7'h00, oe}, 8'h00);
      end
      grant <= 1'b1;
   endtask
   task automatic t_cfg();
      for (int f = 0; f < 4; f++) begin
         set_cfg({2'(f), 6'h00});
         acc(1'b0, 10'h023, 8'h00);
         check("cfg_rd", q, {2'(f), 6'h00});
         check("waits", 8'(w), 8'(f + 1));
      end
      acc(1'b1, 10'h022, 8'h05);
      acc(1'b1, 10'h023, 8'hAA);
      check("cfg_keep", cfg, 8'hC0);
      acc(1'b0, 10'h023, 8'h00);
      check("bad_idx", q, 8'hFF);
   endtask
   task automatic t_dma();
      int         n;
      pdwc_byte_t v;
      for (int k = 0; k < 8; k++) begin
         v = {2'h0, 2'(k), 2'(3 - k), k[2], 1'b0};
         set_cfg(v);
         for (int wd = 0; wd < 2; wd++) begin
            @(posedge clk);
            dstart <= 1'b1;
            dwide <= wd[0];
            @(posedge clk);
            dstart <= 1'b0;
            n = 0;
            do begin
               @(posedge clk);
               n++;
            end while (done !== 1'b1 && n < 40);
            check("dma_len", 8'(n), 8'((k[2] ? 2 : 3) + (wd ? v[5:4] : v[3:2]) + 1));
         end
      end
   endtask
   task automatic t_extend();
      int n;
      @(posedge clk);
      dstart <= 1'b1;
      dwide <= 1'b0;
      pull <= 1'b1;
      @(posedge clk);
      dstart <= 1'b0;
      repeat (8) @(posedge clk);
      check("dma_held", {7'h00, dio_n}, 8'h00);
      check("memr_held", {7'h00, dmr_n}, 8'h00);
      pull <= 1'b0;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (done !== 1'b1 && n < 10);
      check("dma_resume", 8'(n <= 3), 8'h01);
   endtask
   task automatic t_clk();
      int n;
      n = 0;
      repeat (20) begin
         @(posedge clk);
         n = n + clk_en;
      end
      check("div", 8'(n), 8'h0A);
      set_cfg(8'h81);
      repeat (8) @(posedge clk);
      n = 0;
      repeat (20) begin
         @(posedge clk);
         n = n + clk_en;
      end
      check("full", 8'(n), 8'h14);
      acc(1'b0, 10'h023, 8'h00);
      check("waits_byp", 8'(w), 8'h03);
   endtask
   initial begin
      rst_n = 1'b0;
      grant = 1'b1;
      dstart = 1'b0;
      dwide = 1'b0;
      pull = 1'b0;
      sub_rd = 8'h5A;
      errors = 0;
      total_checks = 0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_reset();
      t_decode();
      t_cfg();
      t_dma();
      t_extend();
      t_clk();
      give_verdict();
   end
   // The full sequence needs a few hundred cycles; this bound leaves ample margin.
   initial begin
      #100000;
      errors++;
      give_verdict();
   end
endmodule // tb_peripheral_decode_wait_control
